// ### logic/ext_mem_release.sv
/*
  External memory pin sequencer with bus release handshake and the
  peripheral-direct-transfer strobe, registers over AXI4-Lite.
  Assumes all inputs synchronous to core_clk except the release request.
*/
// Operation
// - SDRAM accesses drive shared strobes as column, write enable, row strobe
// - Transfer strobe asserts only for direct-transfer mode accesses
// - Direct-transfer reads never capture the external data bus
// - Direct-transfer writes leave the data bus undriven
// - Read latency field delays the strobe 0 to 3 cycles
// - Write latency field delays the strobe 0 to 3 cycles
// - Bus floats no sooner than two periods after request falls
// - Grant falls within two periods of the bus floating
// - Bus re-driven two to seven periods after request rises
// - Grant rises within two periods of the bus being driven
// - Floating memory clock follows the same float and re-drive timing
// - Delays counted in selected interface clock periods: external, div4, div6
// - Per-output float bit: 0 keeps clock toggling, 1 floats it
// - Pending memory access completes before the bus is granted
// - With no access in flight, float and grant at minimum delay
// - Defer bit withholds the grant indefinitely
// - Floated set: enables, byte enables, data, address, strobes, clock enable, strobe
`timescale 1ns/1ps
module ext_mem_release #(
  parameter int NCLK = 2
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Access requests from the memory controller core
  input  wire logic              accReq,
  output logic                   accReady,
  input  wire logic              accWrite,
  input  wire logic              accDirect,
  input  wire logic [2:0]        accCmd,
  input  wire logic [3:0]        accChipSel,
  input  wire logic [7:0]        accByteEn,
  input  wire logic [22:3]       accAddr,
  input  wire logic [63:0]       accWdata,
  input  wire logic              accCke,
  output logic                   accBusy,
  output logic [63:0]            accRdata,
  output logic                   accRvalid,
  // Interface clock input
  input  wire logic              interface_clock_input,
  // Bus release handshake
  input  wire logic              busReleaseReq_n,
  output logic                   bus_release_grant_n,
  // External memory pins
  output logic [3:0]             chip_enable_n,
  output logic [7:0]             byte_enable_n,
  output logic [22:3]            ext_address_bus,
  output logic [63:0]            ext_data_bus_out,
  output logic                   ext_data_bus_oe,
  input  wire logic [63:0]       ext_data_bus_in,
  output logic                   sdram_column_strobe_n,
  output logic                   sdram_write_enable_n,
  output logic                   sdram_row_strobe_n,
  output logic                   sdram_clock_enable,
  output logic                   extra_output_enable_n,
  output logic                   direct_xfer_strobe_n,
  output logic                   busOe,
  output logic [NCLK-1:0]        memory_clock_out,
  output logic [NCLK-1:0]        memory_clock_oe
);
  typedef enum logic [2:0] {A_IDLE, A_CMD, A_DATA, A_LAT, A_DONE} acc_st_t;
  typedef enum logic [2:0] {H_RUN, H_WAIT, H_FLOAT, H_HELD, H_RESUME, H_UNGRANT} hold_st_t;

  // Register file
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic [3:0]  lat_ff, nxt_lat;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        wrTake;
  logic        deferBit;
  logic [1:0]  clkSel;

  assign deferBit = ctrl_ff[ext_mem_release_pkg::DEFER_BIT];
  assign clkSel   = ctrl_ff[ext_mem_release_pkg::CLKSEL_LSB +: 2];
  // Address and data taken together; one write outstanding at a time
  assign wrTake        = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // Interface clock enable
  logic [2:0] divCnt_ff, nxt_divCnt;
  logic       extClk_ff, nxt_extClk;
  logic       ifTick;

  // Release request synchroniser and hold state
  logic       reqMeta_ff, reqSync_ff;
  logic       reqLow;
  hold_st_t   holdSt_ff, nxt_holdSt;
  logic [2:0] holdCnt_ff, nxt_holdCnt;
  logic       floated_ff, nxt_floated;
  logic       grantN_ff, nxt_grantN;

  // Access sequencer
  acc_st_t     accSt_ff, nxt_accSt;
  logic [1:0]  latCnt_ff, nxt_latCnt;
  logic        curWrite_ff, nxt_curWrite;
  logic        curDirect_ff, nxt_curDirect;
  logic [63:0] curWdata_ff, nxt_curWdata;
  logic [2:0]  strobes_ff, nxt_strobes;
  logic [3:0]  ce_ff, nxt_ce;
  logic [7:0]  be_ff, nxt_be;
  logic [22:3] addr_ff, nxt_addr;
  logic        cke_ff, nxt_cke;
  logic        dataOe_ff, nxt_dataOe;
  logic        xferN_ff, nxt_xferN;
  logic [63:0] rdCap_ff, nxt_rdCap;
  logic        rdValid_ff, nxt_rdValid;
  logic        memClk_ff, nxt_memClk;
  logic [1:0]  selLat;

  assign reqLow = !reqSync_ff;
  assign selLat = accWrite ? lat_ff[ext_mem_release_pkg::WRLAT_LSB +: 2]
                           : lat_ff[ext_mem_release_pkg::RDLAT_LSB +: 2];

  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_lat    = lat_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (wrTake) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = ext_mem_release_pkg::RESP_OKAY;
      if (s_axi_awaddr == ext_mem_release_pkg::CTRL_OFFS) begin
        if (s_axi_wstrb[0]) nxt_ctrl = s_axi_wdata[7:0];
      end else if (s_axi_awaddr == ext_mem_release_pkg::LAT_OFFS) begin
        if (s_axi_wstrb[0]) nxt_lat = s_axi_wdata[3:0];
      end else if (s_axi_awaddr != ext_mem_release_pkg::STAT_OFFS) begin
        nxt_bresp = ext_mem_release_pkg::RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = ext_mem_release_pkg::RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ext_mem_release_pkg::CTRL_OFFS: nxt_rdata[7:0] = ctrl_ff;
        ext_mem_release_pkg::LAT_OFFS:  nxt_rdata[3:0] = lat_ff;
        ext_mem_release_pkg::STAT_OFFS: begin
          nxt_rdata[ext_mem_release_pkg::GRANT_BIT] = !grantN_ff;
          nxt_rdata[ext_mem_release_pkg::FLOAT_BIT] = floated_ff;
          nxt_rdata[ext_mem_release_pkg::BUSY_BIT]  = accSt_ff != A_IDLE;
        end
        default: nxt_rresp = ext_mem_release_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_ff   <= ext_mem_release_pkg::CTRL_RST;
      lat_ff    <= ext_mem_release_pkg::LAT_RST;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff  <= 2'h0;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      lat_ff    <= nxt_lat;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end
  end

  always_comb begin
    nxt_extClk = interface_clock_input;
    nxt_divCnt = divCnt_ff + 3'h1;
    ifTick     = 1'b0;
    unique case (clkSel)
      ext_mem_release_pkg::CLKSEL_DIV4: ifTick = divCnt_ff == ext_mem_release_pkg::DIV4_CNT - 3'h1;
      ext_mem_release_pkg::CLKSEL_DIV6: ifTick = divCnt_ff == ext_mem_release_pkg::DIV6_CNT - 3'h1;
      default:                          ifTick = interface_clock_input && !extClk_ff;
    endcase
    if (ifTick) nxt_divCnt = 3'h0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divCnt_ff <= 3'h0;
      extClk_ff <= 1'b0;
    end else begin
      divCnt_ff <= nxt_divCnt;
      extClk_ff <= nxt_extClk;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reqMeta_ff <= 1'b1;
      reqSync_ff <= 1'b1;
    end else begin
      reqMeta_ff <= busReleaseReq_n;
      reqSync_ff <= reqMeta_ff;
    end
  end

  always_comb begin
    nxt_holdSt  = holdSt_ff;
    nxt_holdCnt = holdCnt_ff;
    nxt_floated = floated_ff;
    nxt_grantN  = grantN_ff;
    unique case (holdSt_ff)
      H_RUN: begin
        if (reqLow && !deferBit) begin
          nxt_holdSt  = H_WAIT;
          nxt_holdCnt = 3'h0;
        end
      end
      H_WAIT: begin
        if (!reqLow) begin
          nxt_holdSt = H_RUN;
        end else if (ifTick) begin
          if (holdCnt_ff < ext_mem_release_pkg::FLOAT_MIN_E) begin
            nxt_holdCnt = holdCnt_ff + 3'h1;
          end else if (accSt_ff == A_IDLE && !deferBit) begin
            nxt_floated = 1'b1;
            nxt_holdSt  = H_FLOAT;
          end
        end
      end
      H_FLOAT: begin
        if (ifTick) begin
          nxt_grantN = 1'b0;
          nxt_holdSt = H_HELD;
        end
      end
      H_HELD: begin
        if (!reqLow) begin
          nxt_holdSt  = H_RESUME;
          nxt_holdCnt = 3'h0;
        end
      end
      H_RESUME: begin
        if (ifTick) begin
          if (holdCnt_ff < ext_mem_release_pkg::RESUME_MIN_E) begin
            nxt_holdCnt = holdCnt_ff + 3'h1;
          end else begin
            nxt_floated = 1'b0;
            nxt_holdSt  = H_UNGRANT;
          end
        end
      end
      H_UNGRANT: begin
        if (ifTick) begin
          nxt_grantN = 1'b1;
          nxt_holdSt = H_RUN;
        end
      end
      default: nxt_holdSt = H_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdSt_ff  <= H_RUN;
      holdCnt_ff <= 3'h0;
      floated_ff <= 1'b0;
      grantN_ff  <= 1'b1;
    end else begin
      holdSt_ff  <= nxt_holdSt;
      holdCnt_ff <= nxt_holdCnt;
      floated_ff <= nxt_floated;
      grantN_ff  <= nxt_grantN;
    end
  end

  // New accesses refused once a release is requested
  assign accReady = accSt_ff == A_IDLE && ifTick && holdSt_ff == H_RUN && !reqLow;
  assign accBusy  = accSt_ff != A_IDLE;

  always_comb begin
    nxt_accSt     = accSt_ff;
    nxt_latCnt    = latCnt_ff;
    nxt_curWrite  = curWrite_ff;
    nxt_curDirect = curDirect_ff;
    nxt_curWdata  = curWdata_ff;
    nxt_strobes   = strobes_ff;
    nxt_ce        = ce_ff;
    nxt_be        = be_ff;
    nxt_addr      = addr_ff;
    nxt_cke       = cke_ff;
    nxt_dataOe    = dataOe_ff;
    nxt_xferN     = xferN_ff;
    nxt_rdCap     = rdCap_ff;
    nxt_rdValid   = 1'b0;
    nxt_memClk    = ifTick ? !memClk_ff : memClk_ff;
    if (ifTick) begin
      unique case (accSt_ff)
        A_IDLE: begin
          if (accReq && accReady) begin
            nxt_accSt     = A_CMD;
            nxt_curWrite  = accWrite;
            nxt_curDirect = accDirect;
            nxt_curWdata  = accWdata;
            nxt_latCnt    = selLat;
            // command on column, write, row strobes
            nxt_strobes   = ~accCmd;
            nxt_ce        = ~accChipSel;
            nxt_be        = ~accByteEn;
            nxt_addr      = accAddr;
            nxt_cke       = accCke;
          end
        end
        A_CMD: begin
          nxt_strobes = 3'h7;
          nxt_accSt   = A_DATA;
          nxt_dataOe  = curWrite_ff && !curDirect_ff;
          nxt_xferN   = !(curDirect_ff && latCnt_ff == 2'h0);
        end
        A_DATA: begin
          nxt_dataOe = 1'b0;
          nxt_ce     = 4'hf;
          nxt_be     = 8'hff;
          if (!curWrite_ff && !curDirect_ff) begin
            nxt_rdCap   = ext_data_bus_in;
            nxt_rdValid = 1'b1;
          end
          nxt_xferN = !(curDirect_ff && latCnt_ff == 2'h1);
          nxt_accSt = (curDirect_ff && latCnt_ff > 2'h1) ? A_LAT : A_DONE;
          if (latCnt_ff != 2'h0) nxt_latCnt = latCnt_ff - 2'h1;
        end
        A_LAT: begin
          nxt_xferN = !(latCnt_ff == 2'h1);
          nxt_latCnt = latCnt_ff - 2'h1;
          if (latCnt_ff == 2'h1) nxt_accSt = A_DONE;
        end
        A_DONE: begin
          nxt_xferN = 1'b1;
          nxt_accSt = A_IDLE;
        end
        default: nxt_accSt = A_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      accSt_ff     <= A_IDLE;
      latCnt_ff    <= 2'h0;
      curWrite_ff  <= 1'b0;
      curDirect_ff <= 1'b0;
      curWdata_ff  <= 64'h0;
      strobes_ff   <= 3'h7;
      ce_ff        <= 4'hf;
      be_ff        <= 8'hff;
      addr_ff      <= 20'h0;
      cke_ff       <= 1'b1;
      dataOe_ff    <= 1'b0;
      xferN_ff     <= 1'b1;
      rdCap_ff     <= 64'h0;
      rdValid_ff   <= 1'b0;
      memClk_ff    <= 1'b0;
    end else begin
      accSt_ff     <= nxt_accSt;
      latCnt_ff    <= nxt_latCnt;
      curWrite_ff  <= nxt_curWrite;
      curDirect_ff <= nxt_curDirect;
      curWdata_ff  <= nxt_curWdata;
      strobes_ff   <= nxt_strobes;
      ce_ff        <= nxt_ce;
      be_ff        <= nxt_be;
      addr_ff      <= nxt_addr;
      cke_ff       <= nxt_cke;
      dataOe_ff    <= nxt_dataOe;
      xferN_ff     <= nxt_xferN;
      rdCap_ff     <= nxt_rdCap;
      rdValid_ff   <= nxt_rdValid;
      memClk_ff    <= nxt_memClk;
    end
  end

  // pin group shares busOe; data bus and memory clocks add their own enables
  assign busOe                 = !floated_ff;
  assign chip_enable_n         = ce_ff;
  assign byte_enable_n         = be_ff;
  assign ext_address_bus       = addr_ff;
  assign ext_data_bus_out      = curWdata_ff;
  assign ext_data_bus_oe       = dataOe_ff && !floated_ff;
  assign sdram_column_strobe_n = strobes_ff[2];
  assign sdram_write_enable_n  = strobes_ff[1];
  assign sdram_row_strobe_n    = strobes_ff[0];
  assign sdram_clock_enable    = cke_ff;
  assign extra_output_enable_n = 1'b1;
  assign direct_xfer_strobe_n  = xferN_ff;
  assign bus_release_grant_n   = grantN_ff;
  assign accRdata              = rdCap_ff;
  assign accRvalid             = rdValid_ff;

  for (genvar i = 0; i < NCLK; i++) begin : g_clk
    assign memory_clock_out[i] = memClk_ff;
    assign memory_clock_oe[i]  = !(floated_ff && ctrl_ff[ext_mem_release_pkg::FLOAT_LSB + i]);
  end

  // Helper: interface periods since request edge
  logic [3:0] lowTicks_ff, highTicks_ff;
  always_ff @(posedge core_clk) begin
    if (rst || !reqLow) lowTicks_ff <= 4'h0;
    else if (ifTick && lowTicks_ff != 4'hf) lowTicks_ff <= lowTicks_ff + 4'h1;
    if (rst || reqLow) highTicks_ff <= 4'h0;
    else if (ifTick && highTicks_ff != 4'hf) highTicks_ff <= highTicks_ff + 4'h1;
  end

  property p_float_min;
    @(posedge core_clk) disable iff (rst) $fell(busOe) |-> lowTicks_ff >= 4'h2;
  endproperty
  a_float_min: assert property (p_float_min) else $error("bus floated too early");
  property p_grant_after_float;
    @(posedge core_clk) disable iff (rst) $fell(bus_release_grant_n) |-> !busOe;
  endproperty
  a_grant_after_float: assert property (p_grant_after_float) else $error("grant before float");
  property p_resume_window;
    @(posedge core_clk) disable iff (rst)
      $rose(busOe) |-> highTicks_ff >= 4'h2 && highTicks_ff <= 4'h7;
  endproperty
  a_resume_window: assert property (p_resume_window) else $error("re-drive outside window");
  property p_ungrant_after_drive;
    @(posedge core_clk) disable iff (rst) $rose(bus_release_grant_n) |-> busOe;
  endproperty
  a_ungrant_after_drive: assert property (p_ungrant_after_drive) else $error("grant early");
  property p_idle_when_floated;
    @(posedge core_clk) disable iff (rst) !busOe |-> accSt_ff == A_IDLE;
  endproperty
  a_idle_when_floated: assert property (p_idle_when_floated) else $error("access in float");
  property p_defer;
    @(posedge core_clk) disable iff (rst) $fell(busOe) |-> !$past(deferBit);
  endproperty
  a_defer: assert property (p_defer) else $error("released while deferred");
  property p_strobe_direct;
    @(posedge core_clk) disable iff (rst) !direct_xfer_strobe_n |-> curDirect_ff;
  endproperty
  a_strobe_direct: assert property (p_strobe_direct) else $error("strobe on normal access");
  property p_no_capture;
    @(posedge core_clk) disable iff (rst) accRvalid |-> !curDirect_ff && !curWrite_ff;
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("direct read captured");
  property p_hiz_direct;
    @(posedge core_clk) disable iff (rst) ext_data_bus_oe |-> !curDirect_ff;
  endproperty
  a_hiz_direct: assert property (p_hiz_direct) else $error("direct write drove data");
  property p_held;
    @(posedge core_clk) disable iff (rst)
      (holdSt_ff == H_HELD && reqLow) |=> !busOe && !bus_release_grant_n;
  endproperty
  a_held: assert property (p_held) else $error("release dropped early");

  c_grant: cover property (@(posedge core_clk) $fell(bus_release_grant_n));
  c_direct_strobe: cover property (@(posedge core_clk) $fell(direct_xfer_strobe_n));
  c_resume: cover property (@(posedge core_clk) $rose(bus_release_grant_n));
  c_clk_float: cover property (@(posedge core_clk) memory_clock_oe != '1);
endmodule // ext_mem_release

// ### logic/ext_mem_release_pkg.sv
/*
  Constants for the external memory bus-release and direct-transfer block:
  register map, field positions, reset values and interface-period counts.
  Assumes a single core clock; every interface period is an enable pulse.
*/
package ext_mem_release_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFS     = 8'h00;
  localparam logic [7:0] LAT_OFFS      = 8'h04;
  localparam logic [7:0] STAT_OFFS     = 8'h08;
  // Control register fields
  localparam int DEFER_BIT  = 0;
  localparam int CLKSEL_LSB = 1;
  localparam int FLOAT_LSB  = 3;
  // Latency register fields
  localparam int RDLAT_LSB  = 0;
  localparam int WRLAT_LSB  = 2;
  // Status register fields
  localparam int GRANT_BIT  = 0;
  localparam int FLOAT_BIT  = 1;
  localparam int BUSY_BIT   = 2;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] LAT_RST  = 4'h0;
  // Interface clock sources
  localparam logic [1:0] CLKSEL_EXT  = 2'h0;
  localparam logic [1:0] CLKSEL_DIV4 = 2'h1;
  localparam logic [1:0] CLKSEL_DIV6 = 2'h2;
  localparam logic [2:0] DIV4_CNT    = 3'h4;
  localparam logic [2:0] DIV6_CNT    = 3'h6;
  // Release handshake times, in interface periods
  localparam logic [2:0] FLOAT_MIN_E  = 3'h2;
  localparam logic [2:0] RESUME_MIN_E = 3'h2;
  localparam logic [2:0] RESUME_MAX_E = 3'h7;
  localparam logic [2:0] GRANT_MAX_E  = 3'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### tb/far_side_model.sv
/*
  Far-side model: interface clock source and external data input pins.
  Assumes core_clk runs free; one interface period is four core cycles.
*/
`timescale 1ns/1ps
module far_side_model (
  // Clock
  input  wire logic        core_clk,
  // Pins
  output logic             interface_clock_input,
  output logic [63:0]      ext_data_bus_in
);
  logic [1:0] divCnt = 2'h0;
  initial interface_clock_input = 1'b0;
  initial ext_data_bus_in = 64'h0;
  // Nothing holds the bus, so show a pattern that never stays put
  always @(posedge core_clk) begin
    divCnt <= divCnt + 2'h1;
    interface_clock_input <= (divCnt == 2'h3);
    ext_data_bus_in <= ~ext_data_bus_in;
  end
endmodule // far_side_model

// ### tb/tb_top.sv
/*
  Bench for ext_mem_release: register, access and bus release scenarios.
  Assumes the far-side model gives one interface period per four cycles.
*/
`timescale 1ns/1ps
module tb_top;
  logic coreClk = 1'b0, rst = 1'b1;
  logic [7:0] awAddr = 8'h0, arAddr = 8'h0;
  logic [31:0] wData = 32'h0;
  logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic accReq = 0, accWrite = 0, accDirect = 0, reqN = 1;
  logic [2:0] accCmd = 3'h0;
  logic awReady, wReady, bValid, arReady, rValid, accReady, accRvalid;
  logic grantN, dOe, casN, weN, rasN, xferN, busOe, ifClk;
  logic [1:0] bResp, rResp, mclkOe, mclk, r;
  logic [31:0] rData, got;
  logic [63:0] dIn, dOut, rdat, prevIn;
  int badCount = 0, comparisons = 0, cyc = 0, s0, s3;
  logic oe, rv, cs, datOk, busy;
  always #4 coreClk = ~coreClk;
  far_side_model far_side_model_i (.core_clk(coreClk), .interface_clock_input(ifClk),
    .ext_data_bus_in(dIn));
  ext_mem_release ext_mem_release_i (.core_clk(coreClk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .accReq(accReq), .accReady(accReady), .accWrite(accWrite), .accDirect(accDirect),
    .accCmd(accCmd), .accChipSel(wData[3:0]), .accByteEn(wData[7:0]),
    .accAddr(wData[22:3]), .accWdata({2{wData}}), .accCke(1'b1), .accBusy(busy),
    .accRdata(rdat), .accRvalid(accRvalid), .interface_clock_input(ifClk),
    .busReleaseReq_n(reqN), .bus_release_grant_n(grantN), .chip_enable_n(),
    .byte_enable_n(), .ext_address_bus(), .ext_data_bus_out(dOut), .ext_data_bus_oe(dOe),
    .ext_data_bus_in(dIn), .sdram_column_strobe_n(casN), .sdram_write_enable_n(weN),
    .sdram_row_strobe_n(rasN), .sdram_clock_enable(), .extra_output_enable_n(),
    .direct_xfer_strobe_n(xferN), .busOe(busOe), .memory_clock_out(mclk),
    .memory_clock_oe(mclkOe));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge coreClk);
    awAddr <= a; wData <= d; awValid <= 1; wValid <= 1; bReady <= 1;
    @(negedge coreClk); while (!(awReady && wReady)) @(negedge coreClk);
    @(posedge coreClk); awValid <= 0; wValid <= 0;
    @(negedge coreClk); while (!bValid) @(negedge coreClk);
    r = bResp;
    @(posedge coreClk); bReady <= 0;
  endtask
  task automatic axiRd(input logic [7:0] a);
    @(posedge coreClk);
    arAddr <= a; arValid <= 1; rReady <= 1;
    @(negedge coreClk); while (!arReady) @(negedge coreClk);
    @(posedge coreClk); arValid <= 0;
    @(negedge coreClk); while (!rValid) @(negedge coreClk);
    r = rResp; got = rData;
    @(posedge coreClk); rReady <= 0;
  endtask
  // One access; records strobe delay, data drive, capture and command seen
  task automatic access(input logic wr, dir, input logic [2:0] cmd, output int at);
    @(posedge coreClk);
    accReq <= 1; accWrite <= wr; accDirect <= dir; accCmd <= cmd;
    @(negedge coreClk); while (!accReady) @(negedge coreClk);
    @(posedge coreClk); accReq <= 0;
    at = -1; oe = 0; rv = 0; cs = 0; datOk = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge coreClk);
      if (!xferN && at < 0) at = i;
      oe |= dOe; rv |= accRvalid; cs |= ({!casN, !weN, !rasN} == cmd);
      // Capture edge takes the bus value of the cycle before
      if (accRvalid) datOk = (rdat === prevIn);
      if (dOe) datOk = (dOut === {2{wData}});
      prevIn = dIn;
    end
  endtask
  task automatic scAccess();
    for (int w = 0; w < 2; w++) begin
      axiWr(ext_mem_release_pkg::LAT_OFFS, 32'h0);
      access(w[0], 1, w ? 3'h6 : 3'h4, s0);
      chk("direct drive", 0, oe);
      chk("direct capture", 0, rv);
      chk("strobe pins", 1, cs);
      axiWr(ext_mem_release_pkg::LAT_OFFS, 32'hf);
      access(w[0], 1, w ? 3'h6 : 3'h4, s3);
      chk("latency 3", 12, s3 - s0);
      access(w[0], 0, w ? 3'h6 : 3'h4, s3);
      chk("normal strobe", 32'hffffffff, s3);
      chk("normal capture or drive", 1, w ? oe : rv);
      chk("normal data", 1, datOk);
    end
    axiWr(ext_mem_release_pkg::LAT_OFFS, 32'h0);
    axiWr(ext_mem_release_pkg::CTRL_OFFS, 32'h4);
    access(0, 1, 3'h4, s0);
    chk("div6 period", ext_mem_release_pkg::DIV6_CNT, s0);
    axiWr(ext_mem_release_pkg::CTRL_OFFS, 32'h2);
    access(0, 1, 3'h4, s0);
    chk("div4 period", ext_mem_release_pkg::DIV4_CNT, s0);
  endtask
  task automatic scRelease();
    int t;
    axiWr(ext_mem_release_pkg::CTRL_OFFS, 32'h8);
    @(posedge coreClk); reqN <= 0;
    t = 0; @(negedge coreClk); while (busOe && t < 200) begin @(negedge coreClk); t++; end
    chk("float delay", 1, t >= 8 && t <= 16);
    chk("clock float", 2'h2, mclkOe);
    t = 0; while (grantN && t < 20) begin @(negedge coreClk); t++; end
    chk("grant fall", 1, t <= 8);
    cs = mclk[1];
    repeat (4) @(negedge coreClk);
    chk("clock runs in release", !cs, mclk[1]);
    repeat (36) @(negedge coreClk);
    chk("held released", 0, busOe);
    @(posedge coreClk); reqN <= 1;
    t = 0; @(negedge coreClk); while (!busOe && t < 200) begin @(negedge coreClk); t++; end
    chk("resume delay", 1, t >= 8 && t <= 28);
    t = 0; while (!grantN && t < 20) begin @(negedge coreClk); t++; end
    chk("grant rise", 1, t <= 8);
    // Access in flight must finish before the bus floats
    axiWr(ext_mem_release_pkg::LAT_OFFS, 32'hf);
    fork
      access(1, 1, 3'h6, s3);
      begin
        @(negedge coreClk); while (!busy) @(negedge coreClk);
        @(posedge coreClk); reqN <= 0;
        @(negedge coreClk); while (busOe) @(negedge coreClk);
        chk("drained before float", 0, busy);
      end
    join
    chk("strobe in drained access", 16, s3);
    @(posedge coreClk); reqN <= 1;
    @(negedge coreClk); while (!grantN) @(negedge coreClk);
    axiWr(ext_mem_release_pkg::CTRL_OFFS, 32'h1);
    @(posedge coreClk); reqN <= 0;
    repeat (80) @(negedge coreClk);
    chk("deferred", 2'h3, {grantN, busOe});
    @(posedge coreClk); reqN <= 1;
    axiWr(ext_mem_release_pkg::CTRL_OFFS, 32'h0);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge coreClk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge coreClk);
    rst <= 0;
    axiWr(ext_mem_release_pkg::LAT_OFFS, 32'h5);
    chk("write resp", ext_mem_release_pkg::RESP_OKAY, r);
    axiRd(ext_mem_release_pkg::LAT_OFFS);
    chk("latency reg", 32'h5, got);
    axiRd(8'h0c);
    chk("unmapped resp", ext_mem_release_pkg::RESP_SLVERR, r);
    scAccess();
    scRelease();
    conclude();
  end
endmodule // tb_top
